// >>> common/mie_consts.svh
/*
 * Constants for the instruction decode and execute subset: encodings,
 * field positions, reset values and sizes.
 * Assumes inclusion by every file of the block before its package use.
 */
// Function
// RULE1: file-to-file move: two words, write destination late
// RULE2: bank literal load, one cycle, flags kept
// RULE3: accumulator literal load, one cycle, flags kept
// RULE4: literal multiply into product pair, accumulator kept
// RULE5: file multiply into product pair, operands kept
// RULE6: multiplies never touch any status flag
// RULE7: negate file, update N OV C DC Z
// RULE8: access bit low selects access bank
// RULE9: pop discards top return-stack entry
// RULE10: push stores PC plus two on stack
// RULE11: relative call pushes, jumps, second cycle idle
// RULE12: software reset returns all state to reset
// RULE13: interrupt return pops PC, sets interrupt enable
// RULE14: shadow bit restores accumulator, flags, bank
// RULE15: literal return loads accumulator, pops PC
// RULE16: store accumulator to file, flags kept
// RULE17: zero word and lone second word do nothing
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
`define MIE_PC_W       21
`define MIE_STACK_DEPTH 31
`define MIE_Q_LAST     2'h3
`define MIE_ACC_SPLIT  8'h80
`define MIE_ACC_LOW    4'h0
`define MIE_ACC_HIGH   4'hF
`define MIE_FLG_C      0
`define MIE_FLG_DC     1
`define MIE_FLG_Z      2
`define MIE_FLG_OV     3
`define MIE_FLG_N      4
`define MIE_RST_BYTE   8'h00
`define MIE_RST_FLAGS  5'h00
`define MIE_ENC_NOP    16'h0000
`define MIE_ENC_PUSH   16'h0005
`define MIE_ENC_POP    16'h0006
`define MIE_ENC_RESET  16'h00FF
`define MIE_ENC_RETURN_FROM_INTERRUPT 16'b0000_0000_0001_000?
`define MIE_ENC_LBANK  16'h01??
`define MIE_ENC_MULF   16'b0000_001?_????_????
`define MIE_ENC_RETURN_WITH_LITERAL  16'h0C??
`define MIE_ENC_MULL   16'h0D??
`define MIE_ENC_LACC   16'h0E??
`define MIE_ENC_NEG    16'b0110_110?_????_????
`define MIE_ENC_STORE  16'b0110_111?_????_????
`define MIE_ENC_MOVE_FILE_TO_FILE  16'hC???
`define MIE_ENC_RELATIVE_CALL  16'b1101_1???_????_????
`endif

// >>> common/mie_pkg.sv
/*
 * Types of the instruction decode and execute subset.
 * Assumes mie_consts.svh is available on the include path.
 */
`include "mie_consts.svh"
package mie_pkg;
   // Decoded operation
   typedef enum logic [3:0] {
      OP_NOP    = 4'h0,
      OP_MOVE_FILE_TO_FILE  = 4'h1,
      OP_LBANK  = 4'h2,
      OP_LACC   = 4'h3,
      OP_MULL   = 4'h4,
      OP_MULF   = 4'h5,
      OP_NEG    = 4'h6,
      OP_STORE  = 4'h7,
      OP_POP    = 4'h8,
      OP_PUSH   = 4'h9,
      OP_RELATIVE_CALL  = 4'hA,
      OP_RESET  = 4'hB,
      OP_RETURN_FROM_INTERRUPT = 4'hC,
      OP_RETURN_WITH_LITERAL  = 4'hD
   } mie_op_type;
endpackage

// >>> common/mie_stack_if.sv
/*
 * Connection between the execute core and its return stack.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mie_stack_if #(parameter int W = 21);
   logic         push;   // Store wdata as new top
   logic         pop;    // Drop top entry
   logic         flush;  // Empty the stack
   logic [W-1:0] wdata;  // Entry to push
   logic [W-1:0] top;    // Current top entry
   modport core  (output push, pop, flush, wdata, input top);
   modport stack (input push, pop, flush, wdata, output top);
endinterface

// >>> hw/mie_stack.sv
/*
 * Hardware return stack holding program counter values.
 * Assumes one push or pop per request cycle; overflow pushes are dropped
 * and underflow pops are ignored.
 */
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_stack
   import mie_pkg::*;
#(
   parameter int DEPTH = `MIE_STACK_DEPTH,
   parameter int W     = `MIE_PC_W
) (
   input  wire logic   sys_clk_i,
   input  wire logic   reset_n_i,
   mie_stack_if.stack  stk
);
   typedef struct packed {
      logic [4:0] level;  // Entries held
   } mie_stk_state_type;

   logic [W-1:0]      mem [DEPTH];  // Entry store
   mie_stk_state_type s;            // Current state
   mie_stk_state_type next_s;       // Next state
   logic              do_push;      // Push accepted

   assign do_push = stk.push && (s.level < 5'(DEPTH));
   // Top entry, zero when empty
   assign stk.top = (s.level == 5'h00) ? '0 : mem[s.level - 5'h01];

   // Level bookkeeping
   always_comb begin
      next_s = s;
      if (stk.flush) begin
         next_s.level = 5'h00;
      end else if (do_push) begin
         next_s.level = s.level + 5'h01;
      end else if (stk.pop && (s.level != 5'h00)) begin
         next_s.level = s.level - 5'h01;
      end
   end

   // State register and entry write
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
      if (do_push && !stk.flush) begin
         mem[s.level] <= stk.wdata;
      end
   end
endmodule

// >>> hw/mie_core.sv
/*
 * Decode and execute core for a subset of an 8-bit instruction set.
 * Each instruction cycle is four clocks, phases Q1..Q4. Assumes the fetch
 * path presents the word at pc_o during Q1 and the data memory returns
 * read data in the clock after dmem_rd_o and writes when dmem_wr_o is high.
 */
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_core
   import mie_pkg::*;
(
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_n_i,
   input  wire logic [15:0]           instr_i,
   input  wire logic                  instr_valid_i,
   input  wire logic [7:0]            dmem_rdata_i,
   input  wire logic [7:0]            shadow_accumulator_i,
   input  wire logic [4:0]            shadow_flags_i,
   input  wire logic [7:0]            shadow_bank_pointer_i,
   input  wire logic                  irq_high_active_i,
   output logic      [`MIE_PC_W-1:0]  pc_o,
   output logic                       second_cycle_o,
   output logic      [11:0]           dmem_addr_o,
   output logic                       dmem_rd_o,
   output logic                       dmem_wr_o,
   output logic      [7:0]            dmem_wdata_o,
   output logic      [7:0]            accumulator_o,
   output logic      [4:0]            flags_o,
   output logic      [7:0]            bank_pointer_reg_o,
   output logic      [7:0]            product_high_byte_o,
   output logic      [7:0]            product_low_byte_o,
   output logic                       high_prio_irq_enable_o,
   output logic                       low_prio_irq_enable_o,
   output logic                       soft_reset_o
);
   typedef struct packed {
      logic [1:0]           phase;   // Q phase, 0 is Q1
      logic                 second;  // In second cycle
      mie_op_type           op;      // Operation in flight
      logic [15:0]          word;    // First instruction word
      logic [`MIE_PC_W-1:0] pc;      // Address of current word
      logic [11:0]          addr;    // Data address
      logic                 rd;      // Data read strobe
      logic                 wr;      // Data write strobe
      logic [7:0]           wdata;   // Data to write
      logic [7:0]           dlat;    // Read data latch
      logic [7:0]           acc;     // Accumulator
      logic [4:0]           flags;   // N OV Z DC C
      logic [7:0]           bank;    // Bank pointer
      logic [15:0]          prod;    // Product pair
      logic                 gie_h;   // High priority enable
      logic                 gie_l;   // Low priority enable
      logic                 srst;    // Software reset pulse
      logic                 push;    // Stack push
      logic                 pop;     // Stack pop
      logic [`MIE_PC_W-1:0] pdata;   // Stack push value
      logic                 idle;    // No word taken this cycle
   } mie_core_state_type;

   mie_core_state_type s;       // Current state
   mie_core_state_type next_s;  // Next state
   logic [7:0]         neg_res; // Negated read data
   logic [`MIE_PC_W-1:0] pc2;   // Current address plus two

   mie_stack_if #(.W(`MIE_PC_W)) stk ();

   // Word decode into an operation
   function automatic mie_op_type decode(input logic [15:0] w);
      casez (w)
         `MIE_ENC_NOP:    decode = OP_NOP;     // see RULE17
         `MIE_ENC_PUSH:   decode = OP_PUSH;
         `MIE_ENC_POP:    decode = OP_POP;
         `MIE_ENC_RESET:  decode = OP_RESET;
         `MIE_ENC_RETURN_FROM_INTERRUPT: decode = OP_RETURN_FROM_INTERRUPT;
         `MIE_ENC_LBANK:  decode = OP_LBANK;
         `MIE_ENC_MULF:   decode = OP_MULF;
         `MIE_ENC_RETURN_WITH_LITERAL:  decode = OP_RETURN_WITH_LITERAL;
         `MIE_ENC_MULL:   decode = OP_MULL;
         `MIE_ENC_LACC:   decode = OP_LACC;
         `MIE_ENC_NEG:    decode = OP_NEG;
         `MIE_ENC_STORE:  decode = OP_STORE;
         `MIE_ENC_MOVE_FILE_TO_FILE:  decode = OP_MOVE_FILE_TO_FILE;
         `MIE_ENC_RELATIVE_CALL:  decode = OP_RELATIVE_CALL;
         default:         decode = OP_NOP;     // see RULE17
      endcase
   endfunction

   // Banked file address from the access bit and bank pointer
   function automatic logic [11:0] faddr(input logic [15:0] w, input logic [7:0] b);
      if (w[8]) begin
         faddr = {b[3:0], w[7:0]};                 // see RULE8
      end else if (w[7:0] < `MIE_ACC_SPLIT) begin
         faddr = {`MIE_ACC_LOW, w[7:0]};           // see RULE8
      end else begin
         faddr = {`MIE_ACC_HIGH, w[7:0]};          // see RULE8
      end
   endfunction

   // Whether an operation reads the data memory in its first cycle
   function automatic logic reads(input mie_op_type o);
      reads = (o == OP_MOVE_FILE_TO_FILE) || (o == OP_MULF) || (o == OP_NEG);
   endfunction

   // Reset value of the whole state
   function automatic mie_core_state_type rst_state();
      rst_state       = '0;
      rst_state.op    = OP_NOP;
      rst_state.acc   = `MIE_RST_BYTE;
      rst_state.bank  = `MIE_RST_BYTE;
      rst_state.flags = `MIE_RST_FLAGS;
   endfunction

   assign neg_res = 8'(~s.dlat + 8'h01);
   assign pc2     = `MIE_PC_W'(s.pc + `MIE_PC_W'(2));

   // Sequencing and execution of one four-phase cycle
   always_comb begin
      next_s       = s;
      next_s.phase = 2'(s.phase + 2'h1);
      next_s.push  = 1'b0;
      next_s.pop   = 1'b0;
      next_s.srst  = 1'b0;
      case (s.phase)
         2'h0: begin
            // Q1: take a new word, or the second word of a move
            if (s.second) begin
               if (s.op == OP_MOVE_FILE_TO_FILE) begin
                  next_s.addr = instr_i[11:0];       // see RULE1
               end
            end else if (instr_valid_i) begin
               next_s.word = instr_i;
               next_s.idle = 1'b0;
               next_s.op   = decode(instr_i);
               if (decode(instr_i) == OP_MOVE_FILE_TO_FILE) begin
                  next_s.addr = instr_i[11:0];
               end else begin
                  next_s.addr = faddr(instr_i, s.bank);
               end
               next_s.rd = reads(decode(instr_i));
            end else begin
               // Stall: remembered so a late valid cannot skip the word
               next_s.op   = OP_NOP;
               next_s.idle = 1'b1;
            end
         end
         2'h1: begin
            // Q2: end of read strobe
            next_s.rd = 1'b0;
         end
         2'h2: begin
            // Q3: latch read data, set up any write for Q4
            if (!s.second && reads(s.op)) begin
               next_s.dlat = dmem_rdata_i;
            end
            if (s.second && s.op == OP_MOVE_FILE_TO_FILE) begin
               next_s.wr    = 1'b1;                   // see RULE1
               next_s.wdata = s.dlat;
            end else if (!s.second && s.op == OP_NEG) begin
               next_s.wr    = 1'b1;                   // see RULE7
               next_s.wdata = 8'(~dmem_rdata_i + 8'h01);
            end else if (!s.second && s.op == OP_STORE) begin
               next_s.wr    = 1'b1;                   // see RULE16
               next_s.wdata = s.acc;
            end
         end
         2'h3: begin
            // Q4: commit results and choose the next program address
            next_s.wr     = 1'b0;
            next_s.pc     = pc2;
            next_s.second = 1'b0;
            if (!s.second) begin
               case (s.op)
                  OP_MOVE_FILE_TO_FILE: begin
                     next_s.second = 1'b1;             // see RULE1
                  end
                  OP_LBANK: begin
                     next_s.bank = s.word[7:0];        // see RULE2
                  end
                  OP_LACC: begin
                     next_s.acc = s.word[7:0];         // see RULE3
                  end
                  OP_MULL: begin
                     next_s.prod = 16'(s.acc) * 16'(s.word[7:0]);  // see RULE4, RULE6
                  end
                  OP_MULF: begin
                     next_s.prod = 16'(s.acc) * 16'(s.dlat);  // see RULE5, RULE6
                  end
                  OP_NEG: begin
                     next_s.flags[`MIE_FLG_N]  = neg_res[7];         // see RULE7
                     next_s.flags[`MIE_FLG_OV] = (s.dlat == 8'h80);
                     next_s.flags[`MIE_FLG_Z]  = (neg_res == 8'h00);
                     next_s.flags[`MIE_FLG_C]  = (s.dlat == 8'h00);
                     next_s.flags[`MIE_FLG_DC] = (s.dlat[3:0] == 4'h0);
                  end
                  OP_POP: begin
                     next_s.pop = 1'b1;                // see RULE9
                  end
                  OP_PUSH: begin
                     next_s.push  = 1'b1;              // see RULE10
                     next_s.pdata = pc2;
                  end
                  OP_RELATIVE_CALL: begin
                     next_s.push   = 1'b1;             // see RULE11
                     next_s.pdata  = pc2;
                     next_s.pc     = `MIE_PC_W'(pc2 + {{(`MIE_PC_W-12){s.word[10]}},
                                                      s.word[10:0], 1'b0});
                     next_s.second = 1'b1;
                  end
                  OP_RESET: begin
                     next_s      = rst_state();        // see RULE12
                     next_s.srst = 1'b1;
                  end
                  OP_RETURN_FROM_INTERRUPT: begin
                     next_s.pc     = stk.top;          // see RULE13
                     next_s.pop    = 1'b1;
                     next_s.second = 1'b1;
                     if (irq_high_active_i) begin
                        next_s.gie_h = 1'b1;
                     end else begin
                        next_s.gie_l = 1'b1;
                     end
                     if (s.word[0]) begin
                        next_s.acc   = shadow_accumulator_i;   // see RULE14
                        next_s.flags = shadow_flags_i;
                        next_s.bank  = shadow_bank_pointer_i;
                     end
                  end
                  OP_RETURN_WITH_LITERAL: begin
                     next_s.acc    = s.word[7:0];      // see RULE15
                     next_s.pc     = stk.top;
                     next_s.pop    = 1'b1;
                     next_s.second = 1'b1;
                  end
                  default: begin
                     // No operation advances; a stalled cycle holds the address
                     if (s.idle) begin
                        next_s.pc = s.pc;
                     end
                  end
               endcase
            end else if (s.op != OP_MOVE_FILE_TO_FILE) begin
               next_s.pc = s.pc;   // Idle second cycle keeps the new address
            end
         end
         default: begin
            next_s.phase = 2'h0;
         end
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         s <= rst_state();
      end else begin
         s <= next_s;
      end
   end

   assign stk.push  = s.push;
   assign stk.pop   = s.pop;
   assign stk.flush = s.srst;
   assign stk.wdata = s.pdata;

   mie_stack #(.DEPTH(`MIE_STACK_DEPTH), .W(`MIE_PC_W)) u_stack (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .stk       (stk)
   );

   assign pc_o                   = s.pc;
   assign second_cycle_o         = s.second;
   assign dmem_addr_o            = s.addr;
   assign dmem_rd_o              = s.rd;
   assign dmem_wr_o              = s.wr;
   assign dmem_wdata_o           = s.wdata;
   assign accumulator_o          = s.acc;
   assign flags_o                = s.flags;
   assign bank_pointer_reg_o     = s.bank;
   assign product_high_byte_o    = s.prod[15:8];
   assign product_low_byte_o     = s.prod[7:0];
   assign high_prio_irq_enable_o = s.gie_h;
   assign low_prio_irq_enable_o  = s.gie_l;
   assign soft_reset_o           = s.srst;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   logic commit;   // Q4 of a first cycle
   assign commit = (s.phase == `MIE_Q_LAST) && !s.second;

   chk_move_write_late: assert property (s.wr && s.op == OP_MOVE_FILE_TO_FILE |-> s.second && s.phase == 2'h3)  // see RULE1
      else $error("move write outside second cycle Q4");
   chk_bank_load: assert property (commit && s.op == OP_LBANK |=> s.bank == $past(s.word[7:0]) && $stable(s.flags))  // see RULE2
      else $error("bank load wrong");
   chk_acc_load: assert property (commit && s.op == OP_LACC |=> s.acc == $past(s.word[7:0]) && $stable(s.flags))  // see RULE3
      else $error("accumulator load wrong");
   chk_mul_literal: assert property (commit && s.op == OP_MULL |=> s.prod == $past(s.acc) * $past(s.word[7:0]) && $stable(s.acc))  // see RULE4
      else $error("literal product wrong");
   chk_mul_file: assert property (commit && s.op == OP_MULF |=> s.prod == $past(s.acc) * $past(s.dlat) && !s.wr)  // see RULE5
      else $error("file product wrong");
   chk_mul_flags: assert property (commit && (s.op == OP_MULL || s.op == OP_MULF) |=> $stable(s.flags))  // see RULE6
      else $error("multiply changed flags");
   chk_neg_data: assert property (s.wr && s.op == OP_NEG |-> s.wdata == neg_res ##1 s.flags[`MIE_FLG_Z] == (s.wdata == 8'h00))  // see RULE7
      else $error("negate result or zero flag wrong");
   chk_access_bank: assert property (s.rd && s.op != OP_MOVE_FILE_TO_FILE && !s.word[8] |-> s.addr == {(s.word[7] ? `MIE_ACC_HIGH : `MIE_ACC_LOW), s.word[7:0]})  // see RULE8
      else $error("access bank address wrong");
   chk_push_value: assert property (commit && (s.op == OP_PUSH || s.op == OP_RELATIVE_CALL) |=> s.push && s.pdata == $past(pc2))  // see RULE10
      else $error("pushed value wrong");
   chk_relative_call_idle: assert property (commit && s.op == OP_RELATIVE_CALL |=> s.second [*4] ##1 !s.second)  // see RULE11
      else $error("relative call second cycle wrong");
   chk_ret_pop: assert property (commit && (s.op == OP_RETURN_WITH_LITERAL || s.op == OP_RETURN_FROM_INTERRUPT) |=> s.pop && s.pc == $past(stk.top))  // see RULE13
      else $error("return did not pop into pc");
endmodule

// >>> sim/mie_mem_model.sv
/*
 * Behavioural program memory and banked data memory facing the core.
 * Assumes the core drives a byte address on pc_i and single-clock strobes.
 */
`timescale 1ns/1ps
module mie_mem_model (
   input  wire logic        sys_clk_i,
   input  wire logic [20:0] pc_i,
   input  wire logic        stall_i,
   input  wire logic [11:0] dmem_addr_i,
   input  wire logic        dmem_rd_i,
   input  wire logic        dmem_wr_i,
   input  wire logic [7:0]  dmem_wdata_i,
   output logic      [15:0] instr_o,
   output logic             instr_valid_o,
   output logic      [7:0]  dmem_rdata_o
);
   logic [15:0] prog [0:255];  // Program words, one per even address
   logic [7:0]  mem  [0:4095]; // Data space

   // Fetch path answers at once; a stall marks the word not valid
   assign instr_o       = prog[pc_i[8:1]];
   assign instr_valid_o = !stall_i;

   // Read data one clock after the strobe, a changing value otherwise
   always @(posedge sys_clk_i) begin
      if (dmem_rd_i) begin
         dmem_rdata_o <= mem[dmem_addr_i];
      end else begin
         dmem_rdata_o <= ~dmem_rdata_o;
      end
      // Write lands at the strobe edge
      if (dmem_wr_i) begin
         mem[dmem_addr_i] <= dmem_wdata_i;
      end
   end
endmodule

// >>> sim/mie_core_tb_top.sv
/*
 * Self-checking bench for the decode and execute core.
 * Assumes one instruction cycle is four clocks and reset is synchronous.
 */
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_core_tb_top;
   import mie_pkg::*;
   logic        clk, rst_n, stall, irq_hi, rd, wr, sec, sres, gh, gl;
   logic [15:0] instr;
   logic        ivalid;
   logic [7:0]  rdat, wdat, sh_acc, sh_bank, acc, bank, ph, pl;
   logic [4:0]  sh_flg, flg;
   logic [11:0] addr;
   logic [20:0] pc;
   int          bad_count, num_checks, rd_cnt;

   mie_core i_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .instr_i(instr),
      .instr_valid_i(ivalid), .dmem_rdata_i(rdat), .shadow_accumulator_i(sh_acc),
      .shadow_flags_i(sh_flg), .shadow_bank_pointer_i(sh_bank),
      .irq_high_active_i(irq_hi), .pc_o(pc), .second_cycle_o(sec), .dmem_addr_o(addr),
      .dmem_rd_o(rd), .dmem_wr_o(wr), .dmem_wdata_o(wdat), .accumulator_o(acc),
      .flags_o(flg), .bank_pointer_reg_o(bank), .product_high_byte_o(ph),
      .product_low_byte_o(pl), .high_prio_irq_enable_o(gh),
      .low_prio_irq_enable_o(gl), .soft_reset_o(sres));
   mie_mem_model i_mem (.sys_clk_i(clk), .pc_i(pc), .stall_i(stall),
      .dmem_addr_i(addr), .dmem_rd_i(rd), .dmem_wr_i(wr), .dmem_wdata_i(wdat),
      .instr_o(instr), .instr_valid_o(ivalid), .dmem_rdata_o(rdat));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Count data reads to catch a stray second read
   always @(posedge clk) if (rd === 1'b1) rd_cnt++;

   // Closing verdict
   task automatic give_verdict();
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Compare one value
   task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Wait a number of clocks, then step past the edge
   task automatic run(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Load a program over a blank memory and restart the core
   task automatic start(input logic [15:0] p[$]);
      rst_n = 1'b0;
      for (int i = 0; i < 256; i++) i_mem.prog[i] = (i < p.size()) ? p[i] : 16'h0000;
      for (int i = 0; i < 4096; i++) i_mem.mem[i] = 8'h00;
      run(2);
      rd_cnt = 0;
      rst_n  = 1'b1;
   endtask

   // Stall, literal loads, multiply and untouched flags
   task automatic t_literals();
      stall = 1'b1;
      start('{16'h0EE2, 16'h0105, 16'h0DC4, 16'h6C00, 16'h0D00});
      i_mem.mem[12'h000] = 8'h01;
      run(10);
      chk(pc, 21'h0, "stalled pc");
      // Stall lifts in mid cycle; that cycle must still idle
      stall = 1'b0;
      run(14);
      chk({ph, pl}, 16'hAD08, "literal product");
      chk(acc, 8'hE2, "accumulator");
      chk(bank, 8'h05, "bank");
      chk(flg, 5'h00, "flags kept");
      run(8);
      chk({ph, pl}, 16'h0000, "zero product");
      chk(flg, 5'h10, "flags after zero product");
      chk(i_mem.mem[12'h000], 8'hFF, "negate one");
   endtask

   // Stores, banked and access addressing, negate, file multiply
   task automatic t_files();
      start('{16'h0EC4, 16'h6E10, 16'h6E90, 16'h0102, 16'h6D20, 16'h0320, 16'h6C91});
      i_mem.mem[12'h220] = 8'h3A;
      i_mem.mem[12'hF91] = 8'h80;
      run(20);
      chk(flg, 5'h10, "negate flags");
      run(8);
      chk({ph, pl}, 16'h9798, "file product");
      chk(flg, 5'h1A, "negate of 80h flags");
      chk(i_mem.mem[12'h010], 8'hC4, "low access store");
      chk(i_mem.mem[12'hF90], 8'hC4, "high access store");
      chk(i_mem.mem[12'h220], 8'hC6, "banked negate");
      chk(i_mem.mem[12'hF91], 8'h80, "negate 80h");
      chk(acc, 8'hC4, "accumulator kept");
   endtask

   // Two-word move with a single read, then a lone second word
   task automatic t_move();
      start('{16'hC123, 16'hF456, 16'hF777});
      i_mem.mem[12'h123] = 8'h33;
      run(8);
      chk(i_mem.mem[12'h456], 8'h33, "moved byte");
      chk(i_mem.mem[12'h123], 8'h33, "source kept");
      run(4);
      chk(pc, 21'h6, "lone second word");
      chk(rd_cnt, 1, "reads in move");
   endtask

   // Push, push, pop, literal return
   task automatic t_stack();
      start('{16'h0005, 16'h0005, 16'h0006, 16'h0C77});
      run(20);
      chk(pc, 21'h2, "return address");
      chk(acc, 8'h77, "returned literal");
   endtask

   // Forward and backward calls, interrupt return with or without shadows
   task automatic t_call(input logic s, input logic hi);
      irq_hi = hi;
      start('{16'hD807, 16'h0000, 16'h0000, {15'h0008, s}});
      i_mem.prog[8] = 16'hDFF9;
      run(24);
      chk(pc, 21'h12, "pc after interrupt return");
      chk(sec, 1'b1, "return idle cycle");
      chk(acc, s ? 8'h9C : 8'h00, "accumulator");
      chk(flg, s ? 5'h15 : 5'h00, "flags");
      chk(bank, s ? 8'h0E : 8'h00, "bank");
      chk({gh, gl}, hi ? 2'h2 : 2'h1, "interrupt enables");
   endtask

   // Software reset clears loaded state
   task automatic t_reset();
      int n;
      n = 0;
      start('{16'h0E5A, 16'h0107, 16'h00FF});
      run(1);
      while (sres !== 1'b1 && n < 40) begin
         run(1);
         n++;
      end
      chk(sres, 1'b1, "reset pulse");
      chk({acc, bank}, 16'h0000, "state cleared");
   endtask

   // Main sequence
   initial begin
      bad_count = 0;
      num_checks = 0;
      rd_cnt = 0;
      stall = 1'b0;
      irq_hi = 1'b0;
      sh_acc = 8'h9C;
      sh_flg = 5'h15;
      sh_bank = 8'h0E;
      rst_n = 1'b0;
      run(6);
      t_literals();
      t_files();
      t_move();
      t_stack();
      t_call(1'b1, 1'b1);
      t_call(1'b0, 1'b0);
      t_reset();
      give_verdict();
   end

   // Watchdog well beyond the sum of all scenarios
   initial begin
      repeat (2000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule
